// file: verilog/itfd_pkg.sv
/*
  Constants, codes and carrier types for the input terminal function
  decoder. Assumes a 200 MHz system clock and a 32-bit classic Wishbone
  register bus.
*/
// Functional notes
// - Eight selectors, codes 0-32, reset values 6,7,1,18,15,16,8,9 in terminal order.
// - Code 0 makes a terminal do nothing at any level.
// - Code 1 is jog for trial runs; jog frequency defaults to 5 Hz.
// - Code 4 inverts the running direction that would otherwise apply.
// - Forward=6 with reverse=4: forward alone runs forward, both reverse, none stops.
// - Code 5 runs the drive while active.
// - Code 6 runs the motor forward while active.
// - Code 7 runs the motor in reverse while active.
// - Codes 9-12 form a preset index choosing one of fifteen presets.
// - No preset bit active selects the primary frequency reference.
// - Singles give 1-4, pairs 5-10, triples 11-14, all four give 15.
// - Codes 13 and 14 choose one of four ramp time pairs.
// - Ramp bits: none set 1, bit 1 set 2, bit 2 set 3, both set 4.
// - Code 15 raises frequency at a constant rate up to the maximum.
// - Code 16 lowers frequency at a constant rate down to the minimum.
// - Codes 17-26 route to coast, fault reset, PID, sequencer, timers, counter, clear, winding.
// - Terminal direction stays effective and inverts the analog curve direction.
package itfd_pkg;

  localparam int NUM_TERM = 8;
  localparam int CODE_MAX = 32;
  localparam int FREQ_W = 16;

  // Function codes
  localparam logic [5:0] FN_NONE = 6'h00;
  localparam logic [5:0] FN_JOG = 6'h01;
  localparam logic [5:0] FN_JOG_FWD = 6'h02;
  localparam logic [5:0] FN_JOG_REV = 6'h03;
  localparam logic [5:0] FN_DIR_TOGGLE = 6'h04;
  localparam logic [5:0] FN_RUN = 6'h05;
  localparam logic [5:0] FN_FWD = 6'h06;
  localparam logic [5:0] FN_REV = 6'h07;
  localparam logic [5:0] FN_STOP = 6'h08;
  localparam logic [5:0] FN_PRESET1 = 6'h09;
  localparam logic [5:0] FN_RAMP1 = 6'h0d;
  localparam logic [5:0] FN_RAMP2 = 6'h0e;
  localparam logic [5:0] FN_UP = 6'h0f;
  localparam logic [5:0] FN_DOWN = 6'h10;
  localparam logic [5:0] FN_AUX_FIRST = 6'h11;
  localparam int AUX_NUM = 10;

  // Selector reset values, forward input first
  localparam logic [5:0] SEL_RST [NUM_TERM] = '{
    6'h06, 6'h07, 6'h01, 6'h12, 6'h0f, 6'h10, 6'h08, 6'h09};

  // Register byte offsets
  localparam logic [7:0] OFS_SEL0 = 8'h00;
  localparam logic [7:0] OFS_MAIN_FREQ = 8'h20;
  localparam logic [7:0] OFS_MAX_FREQ = 8'h24;
  localparam logic [7:0] OFS_MIN_FREQ = 8'h28;
  localparam logic [7:0] OFS_JOG_FREQ = 8'h2c;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  localparam logic [7:0] OFS_FREQ_CMD = 8'h34;

  // Frequency reset values, 0.01 Hz units
  localparam logic [FREQ_W-1:0] MAIN_FREQ_RST = 16'h0000;
  localparam logic [FREQ_W-1:0] MAX_FREQ_RST = 16'h1388;
  localparam logic [FREQ_W-1:0] MIN_FREQ_RST = 16'h0000;
  localparam logic [FREQ_W-1:0] JOG_FREQ_RST = 16'h01f4;

  // Up/down ramp: one 0.01 Hz step per period
  localparam int CLK_MHZ = 200;
  localparam int UPDN_STEP_US = 100;
  localparam int UPDN_STEP_CYCLES = UPDN_STEP_US * CLK_MHZ;

  typedef struct packed {
    logic run;
    logic dir_rev;
    logic jog;
    logic halt;
    logic use_primary;
    logic [3:0] preset;
    logic [1:0] ramp_set;
    logic freq_up;
    logic freq_down;
    logic [AUX_NUM-1:0] aux;
  } itfd_cmd_t;

endpackage

// file: verilog/itfd_top.sv
/*
  Input terminal function decoder: synchronises eight terminal levels,
  decodes them through per-terminal function selectors into drive
  commands, and keeps the up/down adjusted frequency. Assumes terminal
  pins are asynchronous and active high, the analog direction input comes
  from logic on clk_i, and a classic Wishbone master on clk_i.
*/
// Register access over Wishbone and the register addresses were decided locally.
`timescale 1ns/100ps
module itfd_top #(
  parameter int UPDN_STEP_CYCLES = itfd_pkg::UPDN_STEP_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [itfd_pkg::NUM_TERM-1:0] terminal_i,
  input wire logic analog_dir_rev_i,
  output itfd_pkg::itfd_cmd_t cmd_o,
  output logic [itfd_pkg::FREQ_W-1:0] freq_cmd_o
);

  localparam int NT = itfd_pkg::NUM_TERM;
  localparam int FW = itfd_pkg::FREQ_W;

  generate
    if (UPDN_STEP_CYCLES < 1)
      $error("UPDN_STEP_CYCLES must be at least 1");
  endgenerate

  logic [NT-1:0] term_meta;
  logic [NT-1:0] term_sync;
  logic [5:0] sel [NT];
  logic [FW-1:0] main_freq;
  logic [FW-1:0] max_freq;
  logic [FW-1:0] min_freq;
  logic [FW-1:0] jog_freq;
  logic [FW-1:0] work_freq;
  logic [31:0] step_cnt;
  logic step_tick;
  logic [itfd_pkg::CODE_MAX:0] hit;

  // Two-stage synchroniser; only the second stage feeds the decoder
  always_ff @(posedge clk_i)
  begin
    term_meta <= terminal_i;
    term_sync <= term_meta;
  end

  // Function hit vector: a nonzero code is active when any terminal holding it is on
  always_comb
  begin
    hit = '0;
    for (int t = 0; t < NT; t++)
    begin
      if (term_sync[t] && sel[t] <= 6'(itfd_pkg::CODE_MAX))
        hit[sel[t]] = 1'b1;
    end
    hit[0] = 1'b0;
  end

  // Bus decode
  wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire bus_wr = bus_req && wb_we_i;
  wire [5:0] word_idx = wb_adr_i[7:2];
  wire is_sel = wb_adr_i < 8'(itfd_pkg::OFS_SEL0 + 8'(4 * NT));
  wire wr_main = bus_wr && wb_adr_i == itfd_pkg::OFS_MAIN_FREQ;
  wire wr_max = bus_wr && wb_adr_i == itfd_pkg::OFS_MAX_FREQ;
  wire wr_min = bus_wr && wb_adr_i == itfd_pkg::OFS_MIN_FREQ;
  wire wr_jog = bus_wr && wb_adr_i == itfd_pkg::OFS_JOG_FREQ;
  wire sel_code_ok = wb_dat_i[7:0] <= 8'(itfd_pkg::CODE_MAX);

  function automatic logic [FW-1:0] merge16(input logic [FW-1:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] be);
    merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  // Selector writes above the code range are dropped
  always_ff @(posedge clk_i)
  begin
    for (int t = 0; t < NT; t++)
    begin
      if (rst_i)
        sel[t] <= itfd_pkg::SEL_RST[t];
      else if (bus_wr && is_sel && word_idx == 6'(t) && wb_sel_i[0] &&
               sel_code_ok)
        sel[t] <= wb_dat_i[5:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      main_freq <= itfd_pkg::MAIN_FREQ_RST;
      max_freq <= itfd_pkg::MAX_FREQ_RST;
      min_freq <= itfd_pkg::MIN_FREQ_RST;
      jog_freq <= itfd_pkg::JOG_FREQ_RST;
    end
    else
    begin
      if (wr_main)
        main_freq <= merge16(main_freq, wb_dat_i, wb_sel_i);
      if (wr_max)
        max_freq <= merge16(max_freq, wb_dat_i, wb_sel_i);
      if (wr_min)
        min_freq <= merge16(min_freq, wb_dat_i, wb_sel_i);
      if (wr_jog)
        jog_freq <= merge16(jog_freq, wb_dat_i, wb_sel_i);
    end
  end

  // Step divider for the up/down ramp
  wire [31:0] step_last = 32'(UPDN_STEP_CYCLES - 1);
  always_ff @(posedge clk_i)
  begin
    if (rst_i || step_cnt == step_last)
      step_cnt <= '0;
    else
      step_cnt <= step_cnt + 32'h1;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      step_tick <= 1'b0;
    else
      step_tick <= step_cnt == step_last;
  end

  // Up/down adjusted frequency; not retained, reloads from the main
  // setting at reset and on each write of the main setting
  wire up_only = hit[itfd_pkg::FN_UP] && !hit[itfd_pkg::FN_DOWN];
  wire down_only = hit[itfd_pkg::FN_DOWN] && !hit[itfd_pkg::FN_UP];
  wire [FW-1:0] main_next = merge16(main_freq, wb_dat_i, wb_sel_i);
  wire [FW-1:0] main_clamped = main_next > max_freq ? max_freq :
                               main_next < min_freq ? min_freq : main_next;
  wire can_up = work_freq < max_freq;
  wire can_down = work_freq > min_freq;
  logic [FW-1:0] next_work;
  always_comb
  begin
    next_work = work_freq;
    if (wr_main)
      next_work = main_clamped;
    else if (step_tick && up_only && can_up)
      next_work = work_freq + 16'h0001;
    else if (step_tick && down_only && can_down)
      next_work = work_freq - 16'h0001;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      work_freq <= itfd_pkg::MAIN_FREQ_RST;
    else
      work_freq <= next_work;
  end

  // Preset index from the four select bits
  wire [3:0] preset_bits = hit[itfd_pkg::FN_PRESET1 +: 4];
  logic [3:0] preset_idx;
  always_comb
  begin
    case (preset_bits)
      4'h1: preset_idx = 4'h1;
      4'h2: preset_idx = 4'h2;
      4'h4: preset_idx = 4'h3;
      4'h8: preset_idx = 4'h4;
      4'h3: preset_idx = 4'h5;
      4'h5: preset_idx = 4'h6;
      4'h9: preset_idx = 4'h7;
      4'h6: preset_idx = 4'h8;
      4'ha: preset_idx = 4'h9;
      4'hc: preset_idx = 4'ha;
      4'h7: preset_idx = 4'hb;
      4'hb: preset_idx = 4'hc;
      4'hd: preset_idx = 4'hd;
      4'he: preset_idx = 4'he;
      4'hf: preset_idx = 4'hf;
      default: preset_idx = 4'h0;
    endcase
  end

  // Run and direction
  wire jog_fwd = hit[itfd_pkg::FN_JOG_FWD];
  wire jog_rev = hit[itfd_pkg::FN_JOG_REV];
  wire jog_any = hit[itfd_pkg::FN_JOG] || jog_fwd || jog_rev;
  wire fwd_req = hit[itfd_pkg::FN_FWD] || jog_fwd;
  wire rev_req = hit[itfd_pkg::FN_REV] || jog_rev;
  wire run_req = hit[itfd_pkg::FN_RUN];
  wire normal_run = run_req || hit[itfd_pkg::FN_FWD] ||
                    hit[itfd_pkg::FN_REV];
  wire halt = hit[itfd_pkg::FN_STOP] || hit[itfd_pkg::FN_AUX_FIRST];
  wire next_run = (normal_run || jog_any) && !halt;
  wire base_rev = rev_req && !fwd_req;
  // Toggle applied on top of the curve direction
  wire next_dir = base_rev ^ hit[itfd_pkg::FN_DIR_TOGGLE] ^ analog_dir_rev_i;
  wire jog_freq_sel = jog_any && !normal_run;

  itfd_pkg::itfd_cmd_t next_cmd;
  always_comb
  begin
    next_cmd.run = next_run;
    next_cmd.dir_rev = next_dir;
    next_cmd.jog = jog_any;
    next_cmd.halt = halt;
    next_cmd.use_primary = preset_bits == 4'h0;
    next_cmd.preset = preset_idx;
    // Select 1 is the low bit, so set N is index N-1
    next_cmd.ramp_set = {hit[itfd_pkg::FN_RAMP2], hit[itfd_pkg::FN_RAMP1]};
    next_cmd.freq_up = up_only;
    next_cmd.freq_down = down_only;
    next_cmd.aux = hit[itfd_pkg::FN_AUX_FIRST +: itfd_pkg::AUX_NUM];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cmd_o <= '0;
      freq_cmd_o <= '0;
    end
    else
    begin
      cmd_o <= next_cmd;
      freq_cmd_o <= jog_freq_sel ? jog_freq : work_freq;
    end
  end

  // Read mux; unmapped addresses read zero and still ack
  logic [31:0] rd_data;
  always_comb
  begin
    rd_data = 32'h0;
    if (is_sel)
      rd_data = {26'h0, sel[word_idx[2:0]]};
    else if (wb_adr_i == itfd_pkg::OFS_MAIN_FREQ)
      rd_data = {16'h0, main_freq};
    else if (wb_adr_i == itfd_pkg::OFS_MAX_FREQ)
      rd_data = {16'h0, max_freq};
    else if (wb_adr_i == itfd_pkg::OFS_MIN_FREQ)
      rd_data = {16'h0, min_freq};
    else if (wb_adr_i == itfd_pkg::OFS_JOG_FREQ)
      rd_data = {16'h0, jog_freq};
    else if (wb_adr_i == itfd_pkg::OFS_STATUS)
      rd_data = {1'b0, cmd_o, term_sync};
    else if (wb_adr_i == itfd_pkg::OFS_FREQ_CMD)
      rd_data = {16'h0, freq_cmd_o};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_data : 32'h0;
    end
  end

  // Assertions
  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack not a one-cycle answer");

  property p_sel_range;
    @(posedge clk_i) disable iff (rst_i)
    bus_wr && is_sel && !sel_code_ok |=> $stable(sel[word_idx[2:0]]);
  endproperty
  a_sel_range: assert property (p_sel_range)
    else $error("out-of-range selector code stored");

  property p_stop;
    @(posedge clk_i) disable iff (rst_i)
    hit[itfd_pkg::FN_STOP] |=> !cmd_o.run && cmd_o.halt;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop did not halt the run command");

  property p_fwd_toggle;
    @(posedge clk_i) disable iff (rst_i)
    hit[itfd_pkg::FN_FWD] && hit[itfd_pkg::FN_DIR_TOGGLE] &&
    !hit[itfd_pkg::FN_REV] && !rev_req && !halt
    |=> cmd_o.run && cmd_o.dir_rev == !$past(analog_dir_rev_i);
  endproperty
  a_fwd_toggle: assert property (p_fwd_toggle)
    else $error("forward with toggle did not run reversed");

  property p_rev_only;
    @(posedge clk_i) disable iff (rst_i)
    hit[itfd_pkg::FN_REV] && !fwd_req && !hit[itfd_pkg::FN_DIR_TOGGLE] &&
    !halt |=> cmd_o.run && cmd_o.dir_rev == !$past(analog_dir_rev_i);
  endproperty
  a_rev_only: assert property (p_rev_only)
    else $error("reverse command did not run reverse");

  property p_idle;
    @(posedge clk_i) disable iff (rst_i)
    !normal_run && !jog_any |=> !cmd_o.run;
  endproperty
  a_idle: assert property (p_idle)
    else $error("run without any run command");

  property p_preset_all;
    @(posedge clk_i) disable iff (rst_i)
    preset_bits == 4'hf |=> cmd_o.preset == 4'hf && !cmd_o.use_primary;
  endproperty
  a_preset_all: assert property (p_preset_all)
    else $error("all preset bits did not give preset 15");

  property p_primary;
    @(posedge clk_i) disable iff (rst_i)
    preset_bits == 4'h0 |=> cmd_o.use_primary && cmd_o.preset == 4'h0;
  endproperty
  a_primary: assert property (p_primary)
    else $error("primary reference not selected");

  property p_ramp2;
    @(posedge clk_i) disable iff (rst_i)
    hit[itfd_pkg::FN_RAMP2] && !hit[itfd_pkg::FN_RAMP1]
    |=> cmd_o.ramp_set == 2'h2;
  endproperty
  a_ramp2: assert property (p_ramp2)
    else $error("ramp select 2 alone did not give set 3");

  property p_up_step;
    @(posedge clk_i) disable iff (rst_i)
    step_tick && up_only && can_up && !wr_main
    |=> work_freq == $past(work_freq) + 16'h0001;
  endproperty
  a_up_step: assert property (p_up_step)
    else $error("up step missing");

  property p_down_floor;
    @(posedge clk_i) disable iff (rst_i)
    step_tick && down_only && !can_down && !wr_main
    |=> $stable(work_freq);
  endproperty
  a_down_floor: assert property (p_down_floor)
    else $error("down went below the minimum");

  property p_jog_freq;
    @(posedge clk_i) disable iff (rst_i)
    hit[itfd_pkg::FN_JOG] && !normal_run |=> freq_cmd_o == $past(jog_freq);
  endproperty
  a_jog_freq: assert property (p_jog_freq)
    else $error("jog frequency not selected");

endmodule // itfd_top

// file: bench/itfd_switches.sv
/*
  Far-side model: a bank of eight switch or relay contacts that drive the
  terminal levels. Assumes the bench asks for levels on clk_i and picks
  prompt contacts or slow relays that close some cycles late.
*/
`timescale 1ns/100ps
module itfd_switches (
  input wire logic clk_i,
  input wire logic [7:0] want_i,
  input wire logic slow_i,
  output logic [7:0] level_o
);
  // Relay operate time: four cycles of lag when slow
  logic [31:0] lag = 32'h0000_0000;
  always_ff @(posedge clk_i)
  begin
    lag <= {lag[23:0], want_i};
  end
  assign level_o = slow_i ? lag[31:24] : want_i;
endmodule // itfd_switches

// file: bench/tb.sv
/*
  Self-checking bench for the terminal decoder. Assumes the decoder reports
  decoded commands in its status word and answers Wishbone in one cycle.
*/
`timescale 1ns/100ps
module tb;
  typedef struct packed
  {
    logic [7:0] a;
    logic [31:0] m;
    logic [31:0] e;
  } itfd_note_t;
  localparam logic [3:0] PRE [16] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h3, 4'h6,
    4'h8, 4'hb, 4'h4, 4'h7, 4'h9, 4'hc, 4'ha, 4'hd, 4'he, 4'hf};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, an = 1'b0, slow = 1'b0;
  logic [7:0] adr = 8'h00, want = 8'h00, term;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_w = 32'h0, wb_dat_o;
  logic wb_ack_o;
  itfd_pkg::itfd_cmd_t cmd_o;
  logic [15:0] freq_cmd_o;
  logic [5:0] sel_m [8];
  itfd_note_t q [$];
  itfd_note_t it;
  int n_errors = 0;
  int checked = 0;

  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end

  itfd_switches sw (.clk_i(clk_i), .want_i(want), .slow_i(slow),
    .level_o(term));
  itfd_top #(.UPDN_STEP_CYCLES(8)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .terminal_i(term), .analog_dir_rev_i(an),
    .cmd_o(cmd_o), .freq_cmd_o(freq_cmd_o));

  always @(posedge clk_i)
  begin
    if (wb_ack_o === 1'b1 && we === 1'b0 && q.size() > 0)
    begin
      it = q.pop_front();
      checked++;
      if ((wb_dat_o & it.m) !== (it.e & it.m))
      begin
        n_errors++;
        $display("mismatch reg %h expected %h seen %h", it.a, it.e, wb_dat_o);
      end
      // Pins settled, so the live outputs must agree with the read's expected value
      if (it.a == 8'h30 && cmd_o !== it.e[30:8])
      begin
        n_errors++;
        $display("mismatch cmd_o expected %h seen %h", it.e[30:8], cmd_o);
      end
      if (it.a == 8'h34 && freq_cmd_o !== it.e[15:0])
      begin
        n_errors++;
        $display("mismatch freq_cmd_o expected %h seen %h", it.e[15:0],
          freq_cmd_o);
      end
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // One classic cycle; a read leaves d as its expectation for the monitor,
  // and e marks bits that are left out of the compare
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] e);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    sel <= 4'hf;
    if (!w)
      q.push_back('{a, ~e, d});
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      n_errors++;
      results();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic setsel(input int i, input logic [5:0] v);
    wb(1'b1, 8'(4 * i), {26'h0, v}, 32'h0);
    sel_m[i] = v;
  endtask

  // Pin to command takes three edges, plus relay lag when slow
  task automatic settle(input logic [7:0] w);
    want <= w;
    repeat (12) @(posedge clk_i);
  endtask

  function automatic logic [31:0] exp_st();
    logic [32:0] h;
    itfd_pkg::itfd_cmd_t c;
    logic jg;
    h = '0;
    c = '0;
    for (int i = 0; i < 8; i++)
      if (want[i] && sel_m[i] != 6'h00)
        h[sel_m[i]] = 1'b1;
    jg = h[1] | h[2] | h[3];
    c.jog = jg;
    c.halt = h[8] | h[17];
    c.run = (h[5] | h[6] | h[7] | jg) & !c.halt;
    c.dir_rev = ((h[7] | h[3]) & !(h[6] | h[2])) ^ h[4] ^ an;
    c.preset = PRE[h[12:9]];
    c.use_primary = (h[12:9] == 4'h0);
    c.ramp_set = h[14:13];
    c.freq_up = h[15] & !h[16];
    c.freq_down = h[16] & !h[15];
    c.aux = h[26:17];
    return 32'({c, want});
  endfunction

  initial
  begin
    for (int i = 0; i < 8; i++)
      sel_m[i] = itfd_pkg::SEL_RST[i];
    void'($urandom(64));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 8; i++)
      wb(1'b0, 8'(4 * i), {26'h0, itfd_pkg::SEL_RST[i]}, 32'h0);
    wb(1'b0, 8'h24, 32'h0000_1388, 32'h0);
    wb(1'b0, 8'h2c, 32'h0000_01f4, 32'h0);
    wb(1'b1, 8'h3c, 32'h5a5a_5a5a, 32'h0);
    wb(1'b0, 8'h3c, 32'h0, 32'h0);
    wb(1'b1, 8'h00, 32'h0000_0021, 32'h0);
    wb(1'b0, 8'h00, 32'h0000_0006, 32'h0);
    $display("test registers finished");
    settle(8'h04);
    wb(1'b0, 8'h30, exp_st(), 32'h0);
    wb(1'b0, 8'h34, 32'h0000_01f4, 32'h0);
    setsel(3, 6'h05);
    settle(8'h0c);
    wb(1'b0, 8'h30, exp_st(), 32'h0);
    wb(1'b0, 8'h34, 32'h0, 32'h0);
    $display("test jog finished");
    setsel(3, 6'h12);
    setsel(1, 6'h04);
    slow <= 1'b1;
    foreach (PRE[k])
      if (k < 3)
      begin
        settle(k == 0 ? 8'h01 : (k == 1 ? 8'h03 : 8'h00));
        wb(1'b0, 8'h30, exp_st(), 32'h0);
      end
    slow <= 1'b0;
    $display("test direction finished");
    for (int k = 0; k < 40; k++)
    begin
      setsel(0, 6'(k % 33));
      for (int i = 1; i < 8; i++)
        setsel(i, 6'($urandom_range(32, 0)));
      an <= 1'($urandom);
      settle(8'($urandom));
      wb(1'b0, 8'h30, exp_st(), 32'h0);
    end
    $display("test random decode finished");
    for (int i = 0; i < 8; i++)
      setsel(i, 6'h00);
    setsel(0, 6'h0f);
    setsel(1, 6'h10);
    settle(8'h00);
    wb(1'b1, 8'h24, 32'h0000_0100, 32'h0);
    wb(1'b1, 8'h28, 32'h0000_00f0, 32'h0);
    wb(1'b1, 8'h20, 32'h0000_00fe, 32'h0);
    wb(1'b0, 8'h34, 32'h0000_00fe, 32'h0);
    settle(8'h01);
    repeat (90) @(posedge clk_i);
    wb(1'b0, 8'h34, 32'h0000_0100, 32'h0);
    settle(8'h02);
    repeat (290) @(posedge clk_i);
    wb(1'b0, 8'h34, 32'h0000_00f0, 32'h0);
    // Release down first so no step can race the clamped load
    settle(8'h00);
    wb(1'b1, 8'h20, 32'h0000_2000, 32'h0);
    wb(1'b0, 8'h34, 32'h0000_0100, 32'h0);
    $display("test up down finished");
    results();
  end
endmodule // tb
